//--- rtl/wrc_map.vh
`ifndef WRC_MAP_VH
`define WRC_MAP_VH

// ************************************************************
// Register offsets (byte addresses, one aligned word each)
// ************************************************************
`define WRC_OFF_KEY 12'h000
`define WRC_OFF_UPPER 12'h004
`define WRC_OFF_COUNT 12'h008
`define WRC_OFF_IRQ_STAT 12'h00c
`define WRC_OFF_IRQ_CLR 12'h010
`define WRC_OFF_IRQ_EN 12'h014
`define WRC_OFF_STATE 12'h018

// ************************************************************
// Values and reset values
// ************************************************************
`define WRC_KEY_DISARM 8'h55
`define WRC_KEY_RST 8'h55
`define WRC_CNT_RST 24'h000000
`define WRC_LOW_CLEAR 16'h0000
`define WRC_IRQ_EN_RST 3'h0
`define WRC_IRQ_STAT_RST 3'h0
`define WRC_RDATA_RST 32'h00000000

// ************************************************************
// Field positions
// ************************************************************
`define WRC_IRQ_BITS 3
`define WRC_EV_OVERFLOW 0
`define WRC_EV_RESTART 1
`define WRC_EV_ARMED 2
`define WRC_ST_ARMED 0
`define WRC_ST_SUSPEND 1
`define WRC_ST_RSTREQ 2

`endif

//--- rtl/wrc_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "wrc_map.vh"

// ************************************************************
// 24-bit overflow counter with upper byte load
// ************************************************************
module wrc_counter (
	input wire clk,
	input wire resetn,
	input wire count_en,
	input wire load_en,
	input wire [7:0] load_byte,
	output reg [23:0] count_r,
	output wire wrap
);

	// Carry out of the top bit; a load in the same cycle pre-empts it
	assign wrap = count_en & ~load_en & (&count_r);

	// Load beats increment so a restart is never lost
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= `WRC_CNT_RST;
		end else if (load_en) begin
			count_r <= {load_byte, `WRC_LOW_CLEAR};
		end else if (count_en) begin
			count_r <= count_r + 24'h000001;
		end
	end

endmodule // wrc_counter

`default_nettype wire

//--- rtl/wrc_top.v
// Summary of operation
// - While armed, every counter overflow raises a system reset request.
// - After any reset the watchdog is disarmed: no counting, no resets.
// - Idle or power-down mode stops counting and reset generation.
// - Key value 55h disarms; any other key value arms the watchdog.
// - Any reset loads the key register with 55h.
// - The counter is 24 bits, counting up, cleared to zero on reset.
// - While armed the counter adds one per machine cycle.
// - Overflow issues a reset and reloads the key with 55h.
// - Upper byte write loads bits 23:16 and clears bits 15:0.
// - The upper byte register is a write-only 8-bit port.
`timescale 1ns/100ps
`default_nettype none
`include "wrc_map.vh"

module wrc_top (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire machine_cycle,
	input wire idle_mode,
	input wire power_down_mode,
	output reg sys_reset_req,
	output reg irq
);

	// ************************************************************
	// Declarations
	// ************************************************************
	reg [7:0] key_r;
	reg [7:0] key_nxt;
	reg [`WRC_IRQ_BITS-1:0] irq_stat_r;
	wire [`WRC_IRQ_BITS-1:0] irq_stat_nxt;
	reg [`WRC_IRQ_BITS-1:0] irq_en_r;
	reg [`WRC_IRQ_BITS-1:0] irq_en_nxt;
	reg [1:0] req_state_r;
	reg [1:0] req_state_nxt;
	reg armed_d_r;
	reg [31:0] rdata_nxt;
	wire [23:0] count;
	wire wrap;
	wire armed;
	wire suspended;
	wire count_en;
	wire setup;
	wire access;
	wire wr_acc;
	wire mapped;
	wire sel_key;
	wire sel_upper;
	wire sel_count;
	wire sel_stat;
	wire sel_clr;
	wire sel_en;
	wire sel_state;
	wire rd_setup;
	wire wr_key;
	wire wr_upper;
	wire wr_irq_clr;
	wire wr_irq_en;
	wire [`WRC_IRQ_BITS-1:0] events;
	wire [`WRC_IRQ_BITS-1:0] irq_clr_mask;
	wire [`WRC_IRQ_BITS-1:0] irq_pend;

	// Reset-request states, one-hot
	localparam REQ_IDLE = 2'b01;
	localparam REQ_HOLD = 2'b10;

	// ************************************************************
	// APB decode
	// ************************************************************

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_acc = access & pwrite;
	assign rd_setup = setup & ~pwrite;

	// One-hot register select; low address bits must be zero, so a
	// misaligned address selects nothing instead of aliasing a register
	assign sel_key = (paddr == `WRC_OFF_KEY);
	assign sel_upper = (paddr == `WRC_OFF_UPPER);
	assign sel_count = (paddr == `WRC_OFF_COUNT);
	assign sel_stat = (paddr == `WRC_OFF_IRQ_STAT);
	assign sel_clr = (paddr == `WRC_OFF_IRQ_CLR);
	assign sel_en = (paddr == `WRC_OFF_IRQ_EN);
	assign sel_state = (paddr == `WRC_OFF_STATE);

	// A hole in the map is any address that selects nothing
	assign mapped = sel_key | sel_upper | sel_count | sel_stat |
		sel_clr | sel_en | sel_state;

	// Error only for holes in the map, stores nothing
	assign pslverr = access & ~mapped;

	// Write strobes, one per writable register
	assign wr_key = wr_acc & sel_key;
	assign wr_upper = wr_acc & sel_upper;
	assign wr_irq_clr = wr_acc & sel_clr;
	assign wr_irq_en = wr_acc & sel_en;

	// ************************************************************
	// Arming and suspension
	// ************************************************************

	// Armed is decoded from the key contents, not from a separate bit
	assign armed = (key_r != `WRC_KEY_DISARM);

	// Power manager drives these from the same clock; no synchroniser
	assign suspended = idle_mode | power_down_mode;

	// Count only on machine-cycle strobes while armed and awake
	assign count_en = armed & machine_cycle & ~suspended;

	// ************************************************************
	// Counter
	// ************************************************************
	wrc_counter u_counter (
		.clk(clk),
		.resetn(resetn),
		.count_en(count_en),
		.load_en(wr_upper),
		.load_byte(pwdata[7:0]),
		.count_r(count),
		.wrap(wrap)
	);

	// ************************************************************
	// Key register
	// ************************************************************

	// Overflow reload wins over a software key write in the same cycle
	always @* begin
		key_nxt = key_r;
		if (wrap) begin
			key_nxt = `WRC_KEY_DISARM;
		end else if (wr_key) begin
			key_nxt = pwdata[7:0];
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			key_r <= `WRC_KEY_RST;
		end else begin
			key_r <= key_nxt;
		end
	end

	// ************************************************************
	// Reset request
	// ************************************************************

	// Raised at the wrap strobe, dropped at the next machine-cycle strobe,
	// so the request spans one full machine cycle even at slow strobe rates
	always @* begin
		req_state_nxt = req_state_r;
		case (req_state_r)
			REQ_IDLE: begin
				if (wrap) begin
					req_state_nxt = REQ_HOLD;
				end
			end
			REQ_HOLD: begin
				if (!wrap && machine_cycle) begin
					req_state_nxt = REQ_IDLE;
				end
			end
			default: begin
				req_state_nxt = REQ_IDLE;
			end
		endcase
	end

	// Output is a flop copy of the hold state, so it never glitches
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_state_r <= REQ_IDLE;
			sys_reset_req <= 1'b0;
		end else begin
			req_state_r <= req_state_nxt;
			sys_reset_req <= (req_state_nxt == REQ_HOLD);
		end
	end

	// ************************************************************
	// Interrupt status, enable and clear
	// ************************************************************

	// Delayed armed flag to catch the disarmed-to-armed edge
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed_d_r <= 1'b0;
		end else begin
			armed_d_r <= armed;
		end
	end

	// Event sources; each is a one-cycle pulse
	assign events[`WRC_EV_OVERFLOW] = wrap;
	assign events[`WRC_EV_RESTART] = wr_upper;
	assign events[`WRC_EV_ARMED] = armed & ~armed_d_r;

	// Only a write to the clear register removes bits
	assign irq_clr_mask = wr_irq_clr ? pwdata[`WRC_IRQ_BITS-1:0] : {`WRC_IRQ_BITS{1'b0}};

	// Enable takes a new mask at the access edge
	always @* begin
		irq_en_nxt = irq_en_r;
		if (wr_irq_en) begin
			irq_en_nxt = pwdata[`WRC_IRQ_BITS-1:0];
		end
	end

	// Sticky bits; a new event beats a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < `WRC_IRQ_BITS; gi = gi + 1) begin : g_stat
			assign irq_stat_nxt[gi] = events[gi] |
				(irq_stat_r[gi] & ~irq_clr_mask[gi]);
			assign irq_pend[gi] = irq_stat_nxt[gi] & irq_en_nxt[gi];
		end
	endgenerate

	// Status register
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_r <= `WRC_IRQ_STAT_RST;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// Enable register
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_en_r <= `WRC_IRQ_EN_RST;
		end else begin
			irq_en_r <= irq_en_nxt;
		end
	end

	// Built from next values so the flop matches status and mask as they
	// stand after each edge, with no extra cycle of lag
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |irq_pend;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************

	// Write-only registers and holes read as zero
	always @* begin
		rdata_nxt = 32'h00000000;
		case (paddr)
			`WRC_OFF_KEY: begin
				rdata_nxt[7:0] = key_r;
			end
			`WRC_OFF_COUNT: begin
				rdata_nxt[23:0] = count;
			end
			`WRC_OFF_IRQ_STAT: begin
				rdata_nxt[`WRC_IRQ_BITS-1:0] = irq_stat_r;
			end
			`WRC_OFF_IRQ_EN: begin
				rdata_nxt[`WRC_IRQ_BITS-1:0] = irq_en_r;
			end
			`WRC_OFF_STATE: begin
				rdata_nxt[`WRC_ST_ARMED] = armed;
				rdata_nxt[`WRC_ST_SUSPEND] = suspended;
				rdata_nxt[`WRC_ST_RSTREQ] = (req_state_r == REQ_HOLD);
			end
			default: begin
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Captured in the setup cycle so prdata is a flop during access;
	// the counter value is the one seen at the setup edge
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= `WRC_RDATA_RST;
		end else if (rd_setup) begin
			prdata <= rdata_nxt;
		end
	end

endmodule // wrc_top

`default_nettype wire

//--- dv/wrc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "wrc_map.vh"
// ******
// Port checker
// ******
module wrc_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic machine_cycle,
	input wire logic idle_mode,
	input wire logic power_down_mode,
	input wire logic sys_reset_req,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Request drops on the strobe after it, never earlier
	property p_pulse_end; sys_reset_req && machine_cycle |=> !sys_reset_req; endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
	property p_pulse_hold; sys_reset_req && !machine_cycle |=> sys_reset_req; endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("pulse too short");
	// A new request needs a counting strobe outside sleep modes
	property p_rst_cause; $rose(sys_reset_req) |-> $past(machine_cycle); endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("request without strobe");
	property p_rst_sleep; $rose(sys_reset_req) |-> !$past(idle_mode) && !$past(power_down_mode);
	endproperty
	a_rst_sleep: assert property (p_rst_sleep) else $error("request while asleep");
	// Disarmed after release, so no request soon after
	property p_after_rel; $rose(resetn) |-> !sys_reset_req [*8]; endproperty
	a_after_rel: assert property (p_after_rel) else $error("request after reset");
	property p_upper_wo; psel && !penable && !pwrite && paddr == `WRC_OFF_UPPER |=> prdata == 0;
	endproperty
	a_upper_wo: assert property (p_upper_wo) else $error("upper byte readable");
	property p_err_phase; pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("stray slave error");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
endmodule // wrc_checker
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
// ******
// Bench top
// ******
module tb_top;
	typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} wrc_row_t;
	logic clk, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, irq;
	logic machine_cycle = 0, idle_mode = 0, power_down_mode = 0, sys_reset_req;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	int err_count = 0, check_count = 0;
	// Address, write, data, expected read, expected error
	wrc_row_t rows [9] = '{'{12'h000, 0, 0, 32'h55, 0}, '{12'h008, 0, 0, 0, 0},
		'{12'h004, 0, 0, 0, 0}, '{12'h00c, 0, 0, 0, 0}, '{12'h014, 0, 0, 0, 0},
		'{12'h018, 0, 0, 0, 0}, '{12'h014, 1, 7, 0, 0}, '{12'h014, 0, 0, 7, 0},
		'{12'h01c, 0, 0, 0, 1}};
	wrc_top u_wrc_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .machine_cycle(machine_cycle), .idle_mode(idle_mode),
		.power_down_mode(power_down_mode), .sys_reset_req(sys_reset_req), .irq(irq));
	// Free running clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// One bus transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	// Strobes spaced so each is sampled once
	task automatic strobe(input int n);
		repeat (n) begin
			machine_cycle <= 1;
			@(posedge clk) machine_cycle <= 0;
			@(posedge clk);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard; the overflow run alone takes about 66k cycles
	initial begin
		#750000;
		err_count++;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK(rd, rows[i].x)
			`CHK(err, rows[i].e)
		end
		$display("table done");
		apb(1, 12'h004, 32'h12);
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h120000)
		apb(1, 12'h000, 0);
		strobe(5);
		idle_mode <= 1;
		strobe(3);
		apb(0, 12'h018, 0);
		`CHK(rd, 32'h3)
		idle_mode <= 0;
		power_down_mode <= 1;
		strobe(3);
		power_down_mode <= 0;
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h120005)
		// Key 55h stops the count where it stands
		apb(1, 12'h000, 32'h55);
		strobe(4);
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h120005)
		// Restart in time: low bytes cleared, no request
		apb(1, 12'h000, 32'h01);
		strobe(2);
		apb(1, 12'h004, 32'h00);
		strobe(3);
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h3)
		`CHK(sys_reset_req, 1'b0)
		$display("count done");
		// Run to the last count, then one strobe wraps
		apb(1, 12'h004, 32'hff);
		machine_cycle <= 1;
		repeat (65535) @(posedge clk);
		machine_cycle <= 0;
		apb(0, 12'h008, 0);
		`CHK(rd, 32'hffffff)
		`CHK(sys_reset_req, 1'b0)
		strobe(1);
		`CHK(sys_reset_req, 1'b1)
		apb(0, 12'h018, 0);
		`CHK(rd, 32'h4)
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h55)
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h0)
		apb(0, 12'h00c, 0);
		`CHK(irq, 1'b1)
		`CHK(rd, 32'h7)
		apb(1, 12'h010, 32'h7);
		`CHK(irq, 1'b0)
		apb(0, 12'h00c, 0);
		`CHK(rd, 32'h0)
		// Masked restart event, then unmasked, then cleared
		apb(1, 12'h014, 0);
		apb(1, 12'h004, 0);
		`CHK(irq, 1'b0)
		apb(1, 12'h014, 32'h2);
		`CHK(irq, 1'b1)
		apb(1, 12'h010, 32'h2);
		`CHK(irq, 1'b0)
		strobe(1);
		`CHK(sys_reset_req, 1'b0)
		$display("overflow done");
		// Reset in mid count
		apb(1, 12'h000, 32'ha3);
		strobe(2);
		resetn <= 0;
		repeat (2) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h55)
		strobe(3);
		apb(0, 12'h008, 0);
		`CHK(rd, 32'h0)
		apb(0, 12'h018, 0);
		`CHK(rd, 32'h0)
		`CHK(irq, 1'b0)
		$display("reset done");
		complete_run;
	end
endmodule // tb_top
bind wrc_top wrc_checker u_wrc_checker (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .machine_cycle(machine_cycle), .idle_mode(idle_mode),
	.power_down_mode(power_down_mode), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire
